/* File: core/nv_access_ctrl.sv */
// Purpose: software access to data eeprom and program flash over AHB-Lite
// Assumes: single word transfers, one slave, hready is our hreadyout
// Notes: flash operations stall the bus until they finish
// Notes on behaviour
// - read byte valid next cycle, held until next read or software write
// - write starts only after 55h then 0AAh to unlock, then write start
// - write start is blocked unless write enable gate is already set
// - hardware never clears the write enable gate
// - control, address and data registers frozen while a write runs
// - gate and write start set together in one write start nothing
// - at completion write start clears and done flag is set
// - write enable gate is clear out of reset
// - no write may start while the power-up timer runs
// - flash data staged eight bytes into holding with pointer increment
// - cpu stalls for the whole flash write, about 2 ms
//
// Design decisions made here: the address map and the AHB-Lite slave port.
`include "nv_access_cfg.svh"

module nv_access_ctrl #(
    parameter int PWRT_CYCLES = `NV_PWRT_MS * (`NV_CLK_HZ / 1000),
    parameter int FL_WRITE_CYCLES = `NV_FL_WRITE_MS * (`NV_CLK_HZ / 1000)
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic nv_irq,
    output logic cpu_stall
);

    localparam logic [20:0] PWRT_LOAD = 21'(PWRT_CYCLES);
    localparam logic [20:0] FL_LOAD = 21'(FL_WRITE_CYCLES);
    localparam logic [20:0] EE_LOAD = 21'(`NV_EE_WRITE_CYC);

    function automatic logic hit(input nv_pkg::aphase_t a, input logic [7:0] ofs);
        return a.valid && (a.addr == ofs);
    endfunction : hit

    // ==================================================
    // state
    nv_pkg::aphase_t aph_q;
    nv_pkg::aphase_t aph_d;
    nv_pkg::ctrl_t ctrl_q;
    nv_pkg::ctrl_t ctrl_d;
    nv_pkg::ctrl_t ctrl_wdat;
    nv_pkg::unlock_state_t unlock_q;
    nv_pkg::unlock_state_t unlock_d;
    nv_pkg::op_state_t op_q;
    nv_pkg::op_state_t op_d;
    nv_pkg::hold_t hold_q;
    logic [7:0] addr_q;
    logic [7:0] data_q;
    logic [7:0] data_d;
    logic [7:0] latch_q;
    logic [7:0] latch_d;
    logic [12:0] table_pointer_q;
    logic [12:0] table_pointer_d;
    logic [9:0] hold_base_q;
    logic [1:0] status_q;
    logic [1:0] status_d;
    logic [1:0] mask_q;
    logic [1:0] rd_phase_q;
    logic [1:0] rd_phase_d;
    logic rd_flash_q;
    logic [6:0] step_q;
    logic [6:0] step_d;
    logic boot_q;
    logic [7:0] ee_rdata;
    logic [7:0] fl_rdata;

    // ==================================================
    // bus address phase
    wire addr_take = hsel & htrans[1] & hready & (hsize == 3'h2);

    assign aph_d = addr_take ? '{valid: 1'b1, write: hwrite, addr: haddr[7:0]} : '0;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            aph_q <= '0;
        end else if (hready) begin
            aph_q <= aph_d;
        end
    end

    // ==================================================
    // decode
    wire op_busy = (op_q != nv_pkg::OP_IDLE);
    wire flash_busy = (op_q == nv_pkg::OP_FL_WRITE) | (op_q == nv_pkg::OP_FL_ERASE);
    wire bus_wr = aph_q.valid & aph_q.write & hreadyout;
    wire wr_ctrl = bus_wr & hit(aph_q, `NV_OFS_CTRL);
    wire wr_addr = bus_wr & hit(aph_q, `NV_OFS_ADDR);
    wire wr_data = bus_wr & hit(aph_q, `NV_OFS_DATA);
    wire wr_unlock = bus_wr & hit(aph_q, `NV_OFS_UNLOCK);
    wire wr_status = bus_wr & hit(aph_q, `NV_OFS_STATUS);
    wire wr_mask = bus_wr & hit(aph_q, `NV_OFS_MASK);
    wire wr_table_pointer = bus_wr & hit(aph_q, `NV_OFS_TABLE_POINTER);
    wire wr_tbllat = bus_wr & hit(aph_q, `NV_OFS_TBLLAT);
    wire [7:0] wbyte = hwdata[7:0];

    assign ctrl_wdat = wbyte;

    // ==================================================
    // power-up timer
    wire pwrt_busy;

    nv_countdown u_pwrt (
        .core_clk(core_clk),
        .nrst(nrst),
        .start(~boot_q),
        .load_val(PWRT_LOAD),
        .busy(pwrt_busy),
        .expire()
    );

    wire pwrt_active = ~boot_q | pwrt_busy;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            boot_q <= 1'b0;
        end else begin
            boot_q <= 1'b1;
        end
    end

    // ==================================================
    // write start qualification
    wire unlock_armed = (unlock_q == nv_pkg::UL_ARMED);
    wire ctrl_wr_ok = wr_ctrl & ~op_busy;
    wire wr_request = ctrl_wr_ok & ctrl_wdat.write_start;
    // old gate value, so gate and start in one write never qualify
    wire gate_ok = ctrl_q.write_enable_gate;
    wire start_ok = wr_request & gate_ok & unlock_armed & ~pwrt_active;
    wire start_refused = wr_request & ~start_ok;
    wire rd_issue = ctrl_wr_ok & ctrl_wdat.read_start & ~start_ok & (rd_phase_q == 2'h0);
    wire rd_fresh = (rd_phase_q == 2'h1);
    wire op_expire;
    wire op_done = op_busy & op_expire;

    // ==================================================
    // unlock tracker
    always_comb begin
        unlock_d = unlock_q;
        if (wr_unlock) begin
            unlock_d = nv_pkg::UL_IDLE;
            if (wbyte == `NV_UNLOCK_1) begin
                unlock_d = nv_pkg::UL_GOT_FIRST;
            end else if (wbyte == `NV_UNLOCK_2 && unlock_q == nv_pkg::UL_GOT_FIRST) begin
                unlock_d = nv_pkg::UL_ARMED;
            end
        end else if (bus_wr) begin
            // any other write, the start itself included, uses up the unlock
            unlock_d = nv_pkg::UL_IDLE;
        end
    end

    // ==================================================
    // control register
    always_comb begin
        ctrl_d = ctrl_q;
        if (ctrl_wr_ok) begin
            ctrl_d = ctrl_wdat;
            ctrl_d.spare5 = 1'b0;
            ctrl_d.spare3 = 1'b0;
            ctrl_d.write_start = start_ok;
            ctrl_d.read_start = rd_issue | ctrl_q.read_start;
        end
        if (op_done) begin
            ctrl_d.write_start = 1'b0;
        end
        if (rd_phase_q == 2'h2) begin
            ctrl_d.read_start = 1'b0;
        end
    end

    // ==================================================
    // read sequencing
    assign rd_phase_d = rd_issue ? 2'h1 : (rd_phase_q == 2'h1) ? 2'h2 : 2'h0;
    assign data_d = (rd_fresh & ~rd_flash_q) ? ee_rdata :
                    (wr_data & ~op_busy) ? wbyte : data_q;
    assign latch_d = (rd_fresh & rd_flash_q) ? fl_rdata :
                     wr_tbllat ? wbyte : latch_q;

    // ==================================================
    // table pointer and holding registers
    assign table_pointer_d = wr_table_pointer ? hwdata[12:0] :
                      wr_tbllat ? table_pointer_q + 13'h0001 : table_pointer_q;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            hold_q <= '0;
            hold_base_q <= 10'h000;
        end else if (wr_tbllat) begin
            hold_q[table_pointer_q[2:0]] <= wbyte;
            hold_base_q <= table_pointer_q[12:3];
        end
    end

    // ==================================================
    // operation sequencer
    always_comb begin
        op_d = op_q;
        unique case (op_q)
            nv_pkg::OP_IDLE: begin
                if (start_ok) begin
                    if (!ctrl_wdat.program_memory_select) begin
                        op_d = nv_pkg::OP_EE_WRITE;
                    end else if (ctrl_wdat.row_erase) begin
                        op_d = nv_pkg::OP_FL_ERASE;
                    end else begin
                        op_d = nv_pkg::OP_FL_WRITE;
                    end
                end
            end
            nv_pkg::OP_EE_WRITE, nv_pkg::OP_FL_WRITE, nv_pkg::OP_FL_ERASE: begin
                if (op_expire) begin
                    op_d = nv_pkg::OP_IDLE;
                end
            end
        endcase
    end

    wire [20:0] op_load = ctrl_wdat.program_memory_select ? FL_LOAD : EE_LOAD;

    nv_countdown u_op_timer (
        .core_clk(core_clk),
        .nrst(nrst),
        .start(start_ok),
        .load_val(op_load),
        .busy(),
        .expire(op_expire)
    );

    assign step_d = start_ok ? 7'h00 :
                    (op_busy && step_q < `NV_ROW_BYTES) ? step_q + 7'h01 : step_q;

    // ==================================================
    // memories
    wire erasing = (op_q == nv_pkg::OP_FL_ERASE);
    wire fl_we = ((op_q == nv_pkg::OP_FL_WRITE && step_q < `NV_HOLD_BYTES) ||
                  (erasing && step_q < `NV_ROW_BYTES)) && !ctrl_q.config_space_select;
    wire [12:0] fl_waddr = erasing ? {table_pointer_q[12:6], step_q[5:0]} :
                           {hold_base_q, step_q[2:0]};
    wire [7:0] fl_wdata = erasing ? `NV_ERASED : hold_q[step_q[2:0]];
    wire ee_we = start_ok & ~ctrl_wdat.program_memory_select;

    nv_byte_mem #(.AW(8)) u_eeprom (
        .core_clk(core_clk),
        .nrst(nrst),
        .we(ee_we),
        .waddr(addr_q),
        .wdata(data_q),
        .re(rd_issue & ~ctrl_wdat.program_memory_select),
        .raddr(addr_q),
        .rdata_q(ee_rdata)
    );

    nv_byte_mem #(.AW(13)) u_flash (
        .core_clk(core_clk),
        .nrst(nrst),
        .we(fl_we),
        .waddr(fl_waddr),
        .wdata(fl_wdata),
        .re(rd_issue & ctrl_wdat.program_memory_select),
        .raddr(table_pointer_q),
        .rdata_q(fl_rdata)
    );

    // ==================================================
    // status and interrupt
    logic [1:0] st_set;

    assign st_set[`NV_ST_DONE] = op_done;
    assign st_set[`NV_ST_REFUSED] = start_refused;
    // set wins over a same-cycle clear; only software clears
    assign status_d = (status_q & ~(wr_status ? wbyte[1:0] : 2'h0)) | st_set;
    assign nv_irq = |(status_q & mask_q);

    // ==================================================
    // registers
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= `NV_CTRL_RST;
            unlock_q <= nv_pkg::UL_IDLE;
            op_q <= nv_pkg::OP_IDLE;
            addr_q <= 8'h00;
            data_q <= 8'h00;
            latch_q <= 8'h00;
            table_pointer_q <= 13'h0000;
            status_q <= `NV_ST_RST;
            mask_q <= 2'h0;
            rd_phase_q <= 2'h0;
            rd_flash_q <= 1'b0;
            step_q <= 7'h00;
        end else begin
            ctrl_q <= ctrl_d;
            unlock_q <= unlock_d;
            op_q <= op_d;
            addr_q <= (wr_addr & ~op_busy) ? wbyte : addr_q;
            data_q <= data_d;
            latch_q <= latch_d;
            table_pointer_q <= table_pointer_d;
            status_q <= status_d;
            mask_q <= wr_mask ? wbyte[1:0] : mask_q;
            rd_phase_q <= rd_phase_d;
            rd_flash_q <= rd_issue ? ctrl_wdat.program_memory_select : rd_flash_q;
            step_q <= step_d;
        end
    end

    // ==================================================
    // read data and handshake
    // fresh read bytes bypass so a back-to-back read sees them
    wire [7:0] data_view = (rd_fresh & ~rd_flash_q) ? ee_rdata : data_q;
    wire [7:0] latch_view = (rd_fresh & rd_flash_q) ? fl_rdata : latch_q;
    wire [7:0] rd_byte =
        hit(aph_q, `NV_OFS_CTRL) ? ctrl_q :
        hit(aph_q, `NV_OFS_ADDR) ? addr_q :
        hit(aph_q, `NV_OFS_DATA) ? data_view :
        hit(aph_q, `NV_OFS_STATUS) ? {6'h00, status_q} :
        hit(aph_q, `NV_OFS_MASK) ? {6'h00, mask_q} :
        hit(aph_q, `NV_OFS_TABLE_POINTER) ? table_pointer_q[7:0] :
        hit(aph_q, `NV_OFS_TBLLAT) ? latch_view : 8'h00;
    wire [7:0] rd_hi = hit(aph_q, `NV_OFS_TABLE_POINTER) ? {3'h0, table_pointer_q[12:8]} : 8'h00;

    assign hrdata = {16'h0000, rd_hi, rd_byte};
    // stalling the bus is how the cpu is held during flash work
    assign hreadyout = ~flash_busy;
    assign cpu_stall = flash_busy;
    assign hresp = 1'b0;

endmodule : nv_access_ctrl

/* File: core/nv_byte_mem.sv */
// Purpose: byte-wide memory with registered read data
// Assumes: one write or one read per cycle
// Notes: array itself is not reset
module nv_byte_mem #(
    parameter int AW = 8
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic re,
    input wire logic [AW-1:0] raddr,
    output logic [7:0] rdata_q
);

    // ==================================================
    // storage
    logic [7:0] mem [2**AW];

    always_ff @(posedge core_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= 8'h00;
        end else if (re) begin
            rdata_q <= mem[raddr];
        end
    end

endmodule : nv_byte_mem

/* File: core/nv_countdown.sv */
// Purpose: loadable down counter for write and power-up timing
// Assumes: load_val of zero is treated as one
// Notes: expire is high in the last counted cycle
module nv_countdown (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic start,
    input wire logic [20:0] load_val,
    output logic busy,
    output logic expire
);

    // ==================================================
    // counter
    logic [20:0] count_q;
    logic [20:0] count_d;

    assign count_d = start ? ((load_val == 21'h000000) ? 21'h000001 : load_val) :
                     (count_q != 21'h000000) ? count_q - 21'h000001 : count_q;
    assign busy = (count_q != 21'h000000);
    assign expire = (count_q == 21'h000001);

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            count_q <= 21'h000000;
        end else begin
            count_q <= count_d;
        end
    end

endmodule : nv_countdown

/* File: dv/nv_access_ctrl_asserts.sv */
// Purpose: bus-side assertions for nv_access_ctrl
// Assumes: hready looped back from hreadyout, word transfers only
// Notes: stall length allows slack because the exact end edge is the designer's
`include "nv_access_cfg.svh"
module nv_access_ctrl_asserts #(
    parameter int FL_WRITE_CYCLES = 70
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic nv_irq,
    input wire logic cpu_stall
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========
    // data phase shadow
    logic dph_q;
    logic dwr_q;
    logic [7:0] dad_q;
    logic gok_q;
    logic glast_q;
    logic [20:0] scnt_q;
    wire logic done = dph_q && hready;
    wire logic rd_end = done && !dwr_q;
    wire logic ctl_rd = rd_end && (dad_q == `NV_OFS_CTRL);
    wire logic ctl_wr = done && dwr_q && (dad_q == `NV_OFS_CTRL);
    wire logic fl_go = ctl_wr && hwdata[7] && hwdata[1];
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            dph_q <= 1'b0;
            dwr_q <= 1'b0;
            dad_q <= 8'h00;
            gok_q <= 1'b1;
            glast_q <= 1'b0;
            scnt_q <= 21'h0;
        end else begin
            if (hready) begin
                dph_q <= hsel && htrans[1] && (hsize == 3'h2);
                dwr_q <= hwrite;
                dad_q <= haddr[7:0];
            end
            // any ctrl write makes the remembered gate value stale
            gok_q <= ctl_rd || (gok_q && !ctl_wr);
            if (ctl_rd) glast_q <= hrdata[2];
            scnt_q <= cpu_stall ? scnt_q + 21'h1 : 21'h0;
        end
    end
    // ==========
    // properties
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    sequence s_stall_rise;
        !cpu_stall ##1 cpu_stall;
    endsequence
    property p_okay;
        hresp == 1'b0;
    endproperty
    a_okay: assert property (p_okay) else $error("response not okay");
    property p_stall_ready;
        cpu_stall == !hreadyout;
    endproperty
    a_stall_ready: assert property (p_stall_ready) else $error("stall and ready disagree");
    property p_stall_start;
        s_stall_rise |-> $past(fl_go);
    endproperty
    a_stall_start: assert property (p_stall_start) else $error("stall without start");
    property p_stall_len;
        $fell(cpu_stall) |-> scnt_q >= FL_WRITE_CYCLES - 2 && scnt_q <= FL_WRITE_CYCLES + 1;
    endproperty
    a_stall_len: assert property (p_stall_len) else $error("stall length off");
    property p_stall_max;
        scnt_q <= FL_WRITE_CYCLES + 1;
    endproperty
    a_stall_max: assert property (p_stall_max) else $error("stall too long");
    property p_gate;
        ctl_rd && gok_q |-> hrdata[2] == glast_q;
    endproperty
    a_gate: assert property (p_gate) else $error("gate changed by hardware");
    property p_ctrl_rsv;
        ctl_rd |-> hrdata[31:8] == 24'h0 && !hrdata[5] && !hrdata[3];
    endproperty
    a_ctrl_rsv: assert property (p_ctrl_rsv) else $error("ctrl spare bits set");
    property p_unlock_rd;
        rd_end && dad_q == `NV_OFS_UNLOCK |-> hrdata == 32'h0;
    endproperty
    a_unlock_rd: assert property (p_unlock_rd) else $error("unlock reads nonzero");
    property p_unmapped;
        rd_end && dad_q > `NV_OFS_TBLLAT |-> hrdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped reads nonzero");
    property p_mask_off;
        done && dwr_q && dad_q == `NV_OFS_MASK && hwdata[1:0] == 2'h0 |=> !nv_irq;
    endproperty
    a_mask_off: assert property (p_mask_off) else $error("irq with mask clear");
endmodule : nv_access_ctrl_asserts

bind nv_access_ctrl nv_access_ctrl_asserts #(.FL_WRITE_CYCLES(FL_WRITE_CYCLES)) asserts_i (
    .core_clk(core_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .nv_irq(nv_irq),
    .cpu_stall(cpu_stall)
);

/* File: dv/tb.sv */
// Purpose: self-checking bench for nv_access_ctrl
// Assumes: 25 MHz core_clk, shortened power-up and flash timers
// Notes: hready is looped back from hreadyout
`include "nv_access_cfg.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PWRT = 20;
    localparam int FLW = 70;
    localparam logic [7:0] PRE [4] = '{8'h00, 8'h04, 8'h04, 8'h04};
    localparam logic [7:0] U1 [4] = '{8'h55, 8'hAA, 8'h55, 8'h55};
    localparam logic [7:0] U2 [4] = '{8'hAA, 8'h55, 8'h12, 8'hAA};
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic nv_irq;
    logic cpu_stall;
    logic [31:0] rd;
    int n_fail = 0;
    int tests_run = 0;

    always #20 core_clk = ~core_clk;

    nv_access_ctrl #(.PWRT_CYCLES(PWRT), .FL_WRITE_CYCLES(FLW)) nv_access_ctrl_i (
        .core_clk(core_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .nv_irq(nv_irq),
        .cpu_stall(cpu_stall)
    );

    // ==========
    // bus and check helpers
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // entered just after a rising edge; ready is sampled before that edge's updates land
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : xfer

    task automatic put(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : put

    task automatic get(input string what, input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check(what, rd, exp);
    endtask : get

    task automatic unlock_go(input logic [7:0] u1, input logic [7:0] u2, input logic [31:0] c);
        // nothing else may reach the bus between these three writes
        put(`NV_OFS_UNLOCK, {24'h0, u1});
        put(`NV_OFS_UNLOCK, {24'h0, u2});
        put(`NV_OFS_CTRL, c);
    endtask : unlock_go

    task automatic irq_is(input logic exp);
        @(negedge core_clk);
        check("irq", {31'h0, nv_irq}, {31'h0, exp});
        @(posedge core_clk);
    endtask : irq_is

    // ==========
    // scenarios
    task automatic t_powerup;
        get("ctrl reset", `NV_OFS_CTRL, 32'h0);
        get("status reset", `NV_OFS_STATUS, 32'h0);
        put(`NV_OFS_CTRL, 32'h04);
        unlock_go(8'h55, 8'hAA, 32'h06);
        get("refused early", `NV_OFS_STATUS, 32'h2);
        get("idle early", `NV_OFS_CTRL, 32'h04);
        put(`NV_OFS_STATUS, 32'h3);
        get("unmapped", 8'h20, 32'h0);
        get("unlock reads zero", `NV_OFS_UNLOCK, 32'h0);
        repeat (PWRT) @(posedge core_clk);
        $display("test powerup done");
    endtask : t_powerup

    task automatic t_ee_write;
        int n;
        put(`NV_OFS_ADDR, 32'h3C);
        put(`NV_OFS_DATA, 32'hA5);
        put(`NV_OFS_CTRL, 32'h04);
        unlock_go(8'h55, 8'hAA, 32'h06);
        get("started", `NV_OFS_CTRL, 32'h06);
        put(`NV_OFS_ADDR, 32'h11);
        put(`NV_OFS_DATA, 32'h22);
        put(`NV_OFS_CTRL, 32'h00);
        get("addr frozen", `NV_OFS_ADDR, 32'h3C);
        get("data frozen", `NV_OFS_DATA, 32'hA5);
        n = 0;
        do begin
            xfer(1'b0, `NV_OFS_CTRL, 32'h0);
            n++;
        end while (rd[1] === 1'b1 && n < 400);
        check("start cleared gate kept", rd, 32'h04);
        get("done flag", `NV_OFS_STATUS, 32'h1);
        put(`NV_OFS_MASK, 32'h0);
        irq_is(1'b0);
        put(`NV_OFS_MASK, 32'h1);
        irq_is(1'b1);
        put(`NV_OFS_STATUS, 32'h1);
        irq_is(1'b0);
        get("done cleared", `NV_OFS_STATUS, 32'h0);
        $display("test eeprom write done");
    endtask : t_ee_write

    task automatic t_ee_read;
        put(`NV_OFS_DATA, 32'h00);
        put(`NV_OFS_CTRL, 32'h05);
        get("read byte", `NV_OFS_DATA, 32'hA5);
        get("read start clear", `NV_OFS_CTRL, 32'h04);
        get("byte held", `NV_OFS_DATA, 32'hA5);
        $display("test eeprom read done");
    endtask : t_ee_read

    // gate set with start, reversed, wrong value, and a write in between
    task automatic t_unlock_order;
        for (int i = 0; i < 4; i++) begin
            put(`NV_OFS_CTRL, {24'h0, PRE[i]});
            put(`NV_OFS_UNLOCK, {24'h0, U1[i]});
            put(`NV_OFS_UNLOCK, {24'h0, U2[i]});
            if (i == 3) put(`NV_OFS_ADDR, 32'h3C);
            put(`NV_OFS_CTRL, 32'h06);
            get("bad order refused", `NV_OFS_STATUS, 32'h2);
            get("bad order idle", `NV_OFS_CTRL, 32'h04);
            put(`NV_OFS_STATUS, 32'h2);
        end
        $display("test unlock order done");
    endtask : t_unlock_order

    // read start is still set one transfer later, so the latch is read first
    task automatic fl_read(input string what, input logic [12:0] a, input logic [31:0] exp);
        put(`NV_OFS_TABLE_POINTER, {19'h0, a});
        put(`NV_OFS_CTRL, 32'h85);
        get(what, `NV_OFS_TBLLAT, exp);
        get("read idle", `NV_OFS_CTRL, 32'h84);
    endtask : fl_read

    // erase the row, then stage and write it eight bytes at a time
    task automatic t_flash;
        int n;
        put(`NV_OFS_TABLE_POINTER, 32'h40);
        for (int r = 0; r < 9; r++) begin
            for (int i = 0; i < 8 && r > 0; i++) begin
                put(`NV_OFS_TBLLAT, 32'h08 + 8 * r + i);
            end
            put(`NV_OFS_CTRL, (r == 0) ? 32'h94 : 32'h84);
            unlock_go(8'h55, 8'hAA, (r == 0) ? 32'h96 : 32'h86);
            n = 0;
            @(posedge core_clk);
            while (cpu_stall === 1'b1 && n < 1000) begin
                n++;
                @(posedge core_clk);
            end
            check("stall length", {31'h0, (n >= FLW - 2 && n <= FLW + 1)}, 32'h1);
            get("flash done", `NV_OFS_STATUS, 32'h1);
            put(`NV_OFS_STATUS, 32'h1);
            if (r == 0) fl_read("erased byte", 13'h040, 32'hFF);
        end
        get("pointer stepped", `NV_OFS_TABLE_POINTER, 32'h80);
        get("flash idle", `NV_OFS_CTRL, 32'h84);
        fl_read("flash byte", 13'h040, 32'h10);
        fl_read("row end", 13'h07F, 32'h4F);
        $display("test flash write done");
    endtask : t_flash

    // ==========
    // run control
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : complete_run

    // about 1,250 cycles expected; generous margin
    initial begin
        #200000;
        n_fail++;
        complete_run();
    end

    initial begin
        repeat (4) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        t_powerup();
        t_ee_write();
        t_ee_read();
        t_unlock_order();
        t_flash();
        complete_run();
    end
endmodule : tb

/* File: shared/nv_access_cfg.svh */
// Purpose: constants for the nonvolatile access controller
// Assumes: 25 MHz core_clk, AHB-Lite word registers
// Notes: offsets are byte addresses, one word per register
`ifndef NV_ACCESS_CFG_SVH
`define NV_ACCESS_CFG_SVH

// ==================================================
// clock and timing
`define NV_CLK_HZ 25000000
`define NV_PWRT_MS 72
`define NV_FL_WRITE_MS 2
// no time is known for a data byte write: plain cycle count
`define NV_EE_WRITE_CYC 200

// ==================================================
// unlock values and sizes
`define NV_UNLOCK_1 8'h55
`define NV_UNLOCK_2 8'hAA
`define NV_HOLD_BYTES 7'h08
`define NV_ROW_BYTES 7'h40
`define NV_ERASED 8'hFF

// ==================================================
// register offsets
`define NV_OFS_CTRL 8'h00
`define NV_OFS_ADDR 8'h04
`define NV_OFS_DATA 8'h08
`define NV_OFS_UNLOCK 8'h0C
`define NV_OFS_STATUS 8'h10
`define NV_OFS_MASK 8'h14
`define NV_OFS_TABLE_POINTER 8'h18
`define NV_OFS_TBLLAT 8'h1C

// ==================================================
// field positions and reset values
`define NV_ST_DONE 0
`define NV_ST_REFUSED 1
`define NV_CTRL_RST 8'h00
`define NV_ST_RST 2'h0

`endif

/* File: shared/nv_pkg.sv */
// Purpose: types for the nonvolatile access controller
// Assumes: nothing beyond the cfg header
// Notes: constants live in nv_access_cfg.svh
package nv_pkg;

    // ==================================================
    // control register layout
    typedef struct packed {
        logic program_memory_select;
        logic config_space_select;
        logic spare5;
        logic row_erase;
        logic spare3;
        logic write_enable_gate;
        logic write_start;
        logic read_start;
    } ctrl_t;

    // ==================================================
    // bus and sequencing
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
    } aphase_t;

    typedef enum logic [1:0] {UL_IDLE, UL_GOT_FIRST, UL_ARMED} unlock_state_t;

    typedef enum logic [1:0] {OP_IDLE, OP_EE_WRITE, OP_FL_WRITE, OP_FL_ERASE} op_state_t;

    typedef logic [7:0][7:0] hold_t;

endpackage : nv_pkg
